//--- core/xdp_defs.vh
/*
  constants for the peripheral bus decoder: i/o ports, rom window defaults
  assumes includers use the macros as sized literals
*/
`ifndef XDP_DEFS_VH
`define XDP_DEFS_VH
`define XDP_PORT_KBD_DATA   16'h0060
`define XDP_PORT_KBD_STAT   16'h0064
`define XDP_PORT_RTC_ADDR   16'h0070
`define XDP_PORT_RTC_DATA   16'h0071
`define XDP_ROM_BASE        32'h000E0000
`define XDP_ROM_LIMIT       32'h000FFFFF
`define XDP_SYNC_STAGES     3
`endif

//--- core/xdp_pin_sync.v
/*
  three-stage synchroniser bank with agreement filter for pin inputs
  assumes a single clock domain clk_sys and asynchronous active-low reset
*/
`timescale 1ns/10ps
`default_nettype none
module xdp_pin_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             nrst,
  // pins and filtered levels
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;

  // three flops; level moves only when stages two and three agree
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1    <= {WIDTH{1'b0}};
      s2    <= {WIDTH{1'b0}};
      s3    <= {WIDTH{1'b0}};
      level <= {WIDTH{1'b0}};
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level <= (s2 & s3) | (level & (s2 | s3));
    end
  end
endmodule // xdp_pin_sync
`default_nettype wire

//--- core/xdp_decode.v
/*
  peripheral (xd) bus decoder: rom select, rtc strobes, keyboard select,
  xd buffer direction, a20 mask or gate, l2 pin reuse.
  assumes command pins and aen come from the cycle engine (synchronised
  here), cycle address and flags unsynchronised; rom window and mode straps are static configuration inputs.
*/
// Behaviour
// RL1: the rtc address strobe is active whenever port 70h is accessed; the code blanks it while aen is high.
// RL2: for port 70h cycles a data qualifier is driven for rtc strobe use.
// RL3: the rom select is active only for memory cycles in the rom window.
// RL4: with l2 fitted, rom select and rtc qualifier share a pin, rtc only with aen low.
// RL5: outside logic gates the keyboard select with aen to make the chip select.
// RL6: the xd buffer direction is high by default, meaning toward the xd device.
// RL7: the direction goes low while rom select and memory read are both active.
// RL8: the direction goes low for reads from ports 060h, 064h, 070h and 071h.
// RL9: 486 mode drives an a20 mask; 386 mode uses a two-way gated a20 pin.
// RL10: with l2 fitted, keyboard, qualifier and direction pins carry l2 controls.
// RL11: aen marks dma ownership of the bus, so decodes do not answer then (the rom decode ignores aen).
`timescale 1ns/10ps
`default_nettype none
`include "xdp_defs.vh"
module xdp_decode #(
  parameter [31:0] ROM_BASE  = `XDP_ROM_BASE,
  parameter [31:0] ROM_LIMIT = `XDP_ROM_LIMIT
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // cycle from the bus engine
  input  wire [31:0] cyc_addr,
  input  wire        cyc_active,
  input  wire        cyc_is_mem,
  input  wire        cyc_is_write,
  input  wire        memory_read_cmd_n,
  input  wire        io_read_cmd_n,
  input  wire        aen,
  // configuration straps
  input  wire        l2_fitted,
  input  wire        mode_486,
  input  wire        a20_force_mask,
  input  wire        a20_gate_req,
  // l2 control requests from the cache engine
  input  wire        l2_data_enable_low_req,
  input  wire        l2_data_enable_high_req,
  input  wire        l2_data_dir_req,
  // xd bus outputs
  output reg         rtc_addr_strobe,
  output reg         boot_rom_select_n,
  output reg         rtc_data_qualifier_n,
  output reg         keyboard_ctrl_select_n,
  output reg         xd_buffer_direction,
  // a20 pin, two-way in 386 mode
  input  wire        gated_addr20_in,
  output reg         gated_addr20_out,
  output reg         gated_addr20_oe_n
);
  // pin inputs pass the synchroniser; active-low and pulled-up pins are
  // inverted around it so that its all-zero reset matches their idle level
  // and no false command shows for the first edges after reset
  wire [3:0] sync_lvl;
  xdp_pin_sync #(.WIDTH(4)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin_in  ({aen, ~memory_read_cmd_n, ~io_read_cmd_n, ~gated_addr20_in}),
    .level   (sync_lvl)
  );
  wire aen_s    = sync_lvl[3];
  wire mrd_n_s  = ~sync_lvl[2];
  wire iord_n_s = ~sync_lvl[1];
  wire gated_addr20_s   = ~sync_lvl[0];

  // cycle straps captured after reset release
  reg l2_cfg;
  reg m486_cfg;
  reg cfg_done;

  function is_io_port;
    input [31:0] a;
    input [15:0] port;
    begin
      is_io_port = (a[15:0] == port);
    end
  endfunction

  // decode terms; aen blanks processor i/o decodes
  wire cpu_io  = cyc_active & ~cyc_is_mem & ~aen_s; // [RL11]
  wire hit_70  = cpu_io & is_io_port(cyc_addr, `XDP_PORT_RTC_ADDR);
  wire hit_71  = cpu_io & is_io_port(cyc_addr, `XDP_PORT_RTC_DATA);
  wire hit_kbd = cpu_io & (is_io_port(cyc_addr, `XDP_PORT_KBD_DATA) |
                           is_io_port(cyc_addr, `XDP_PORT_KBD_STAT));
  wire rom_hit = cyc_active & cyc_is_mem &
                 (cyc_addr >= ROM_BASE) & (cyc_addr <= ROM_LIMIT); // [RL3]
  wire io_rd   = ~iord_n_s & ~cyc_is_write;

  reg next_dir;
  reg next_rom_n;
  reg next_rtc_data_qualifier_n_n;

  // direction low for rom reads and listed port reads, else high
  always @* begin
    next_dir = 1'b1; // [RL6]
    if (rom_hit & ~mrd_n_s)
      next_dir = 1'b0; // [RL7]
    if (io_rd & (hit_kbd | hit_70 | hit_71))
      next_dir = 1'b0; // [RL8]
  end

  // shared pin with l2: rom select whatever aen is, rtc qualifier added while aen low
  always @* begin
    next_rtc_data_qualifier_n_n = ~hit_70; // [RL2]
    next_rom_n  = ~rom_hit; // [RL3]
    if (l2_cfg && !aen_s)
      next_rom_n = ~(rom_hit | hit_70); // [RL4]
  end

  // strap capture at release
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      l2_cfg   <= 1'b0;
      m486_cfg <= 1'b1;
      cfg_done <= 1'b0;
    end else if (!cfg_done) begin
      l2_cfg   <= l2_fitted;
      m486_cfg <= mode_486;
      cfg_done <= 1'b1;
    end
  end

  // registered outputs
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rtc_addr_strobe        <= 1'b0;
      boot_rom_select_n      <= 1'b1;
      rtc_data_qualifier_n   <= 1'b1;
      keyboard_ctrl_select_n <= 1'b1;
      xd_buffer_direction    <= 1'b1;
      gated_addr20_out       <= 1'b1;
      gated_addr20_oe_n      <= 1'b0;
    end else begin
      rtc_addr_strobe   <= hit_70; // [RL1]
      boot_rom_select_n <= next_rom_n;
      if (l2_cfg) begin
        rtc_data_qualifier_n   <= ~l2_data_enable_low_req; // [RL10]
        keyboard_ctrl_select_n <= ~l2_data_enable_high_req; // [RL10]
        xd_buffer_direction    <= l2_data_dir_req; // [RL10]
      end else begin
        rtc_data_qualifier_n   <= next_rtc_data_qualifier_n_n; // [RL2]
        keyboard_ctrl_select_n <= ~hit_kbd; // [RL5]
        xd_buffer_direction    <= next_dir;
      end
      if (m486_cfg) begin
        gated_addr20_out  <= ~a20_force_mask; // [RL9]
        gated_addr20_oe_n <= 1'b0;
      end else begin
        // 386: drive only when forced, otherwise follow the external gate
        gated_addr20_out  <= a20_gate_req & ~a20_force_mask & gated_addr20_s; // [RL9]
        gated_addr20_oe_n <= ~a20_force_mask;
      end
    end
  end
endmodule // xdp_decode
`default_nettype wire

//--- verif/xdp_decode_chk.sv
/* checker on the xdp_decode ports
   assumes one clock and straps held steady across each reset */
`timescale 1ns/10ps
`default_nettype none
module xdp_decode_chk #(
  parameter [31:0] ROM_BASE  = 32'h000E0000,
  parameter [31:0] ROM_LIMIT = 32'h000FFFFF
) (
  input wire logic        clk_sys, nrst, cyc_active, cyc_is_mem, aen,
  input wire logic [31:0] cyc_addr,
  input wire logic        memory_read_cmd_n, io_read_cmd_n, l2_fitted,
  input wire logic        mode_486, a20_force_mask, l2_data_dir_req,
  input wire logic        l2_data_enable_low_req, rtc_addr_strobe,
  input wire logic        boot_rom_select_n, rtc_data_qualifier_n,
  input wire logic        xd_buffer_direction, gated_addr20_out,
  input wire logic        gated_addr20_oe_n
);
  // cycle kinds seen at the inputs
  wire [15:0] pt  = cyc_addr[15:0];
  wire        io  = cyc_active && !cyc_is_mem && !aen && !l2_fitted;
  wire        rom = cyc_active && cyc_is_mem && cyc_addr >= ROM_BASE
                    && cyc_addr <= ROM_LIMIT;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_rtc; (io && pt == 16'h0070)[*6] |=> rtc_addr_strobe
    && !rtc_data_qualifier_n; endproperty
  a_rtc: assert property (p_rtc) else $error("rtc strobe");
  property p_rom; rom |=> !boot_rom_select_n; endproperty
  a_rom: assert property (p_rom) else $error("rom select");
  property p_dir_def; (!cyc_active && memory_read_cmd_n && io_read_cmd_n
    && !l2_fitted)[*6] |=> xd_buffer_direction; endproperty
  a_dir_def: assert property (p_dir_def) else $error("dir idle");
  property p_dir_rom; (rom && !memory_read_cmd_n && !l2_fitted)[*6]
    |=> !xd_buffer_direction; endproperty
  a_dir_rom: assert property (p_dir_rom) else $error("dir rom");
  property p_dir_io; (io && !io_read_cmd_n && pt inside {16'h0060,
    16'h0064, 16'h0070, 16'h0071})[*6] |=> !xd_buffer_direction;
  endproperty
  a_dir_io: assert property (p_dir_io) else $error("dir io");
  property p_aen; aen[*6] |=> !rtc_addr_strobe; endproperty
  a_aen: assert property (p_aen) else $error("aen strobe");
  property p_a20; mode_486 |=> !gated_addr20_oe_n
    && gated_addr20_out == !$past(a20_force_mask); endproperty
  a_a20: assert property (p_a20) else $error("a20 mask");
  property p_l2; l2_fitted && $past(l2_fitted) && $past(nrst)
    |=> xd_buffer_direction == $past(l2_data_dir_req)
    && rtc_data_qualifier_n == !$past(l2_data_enable_low_req); endproperty
  a_l2: assert property (p_l2) else $error("l2 pins");
  c_rtc: cover property (rtc_addr_strobe);
  c_rom: cover property (!boot_rom_select_n && !xd_buffer_direction);
  c_l2: cover property (l2_fitted && !rtc_data_qualifier_n);
endmodule // xdp_decode_chk
bind xdp_decode xdp_decode_chk #(.ROM_BASE(ROM_BASE),
  .ROM_LIMIT(ROM_LIMIT)) chk (.*);
`default_nettype wire

//--- verif/xdp_periph_model.sv
/* xd-bus side: a20 wire with pull-up, keyboard chip select gating
   assumes the decoder pin trio and aen come from the bench */
`timescale 1ns/10ps
`default_nettype none
module xdp_periph_model (
  input  wire logic a_out, a_oe_n, kbd_n, aen,
  output wire logic a_in, kbd_cs_n
);
  // released wire rises to the pull-up, chip select gated by aen
  assign a_in = a_oe_n ? 1'b1 : a_out;
  assign kbd_cs_n = kbd_n | aen;
endmodule // xdp_periph_model
`default_nettype wire

//--- verif/testbench.sv
/* bench for xdp_decode: io and rom decode, direction, a20, l2 reuse
   assumes the core/ design files are compiled first */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 0, nrst = 0, act = 0, mem = 0, mrd_n = 1, ird_n = 1;
  logic aen = 0, l2 = 0, frc = 0, el = 0, m486 = 1;
  logic [31:0] adr = 0;
  wire rtc, rom_n, q_n, kb_n, dir, a_in, a_out, a_oe, kcs_n;
  int error_cnt = 0, n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  xdp_decode uut (.clk_sys, .nrst, .cyc_addr(adr), .cyc_active(act),
    .cyc_is_mem(mem), .cyc_is_write(1'b0), .memory_read_cmd_n(mrd_n),
    .io_read_cmd_n(ird_n), .aen, .l2_fitted(l2), .mode_486(m486),
    .a20_force_mask(frc), .a20_gate_req(1'b0), .l2_data_dir_req(1'b0),
    .l2_data_enable_low_req(el), .l2_data_enable_high_req(el),
    .rtc_addr_strobe(rtc), .boot_rom_select_n(rom_n),
    .rtc_data_qualifier_n(q_n), .keyboard_ctrl_select_n(kb_n),
    .xd_buffer_direction(dir), .gated_addr20_in(a_in),
    .gated_addr20_out(a_out), .gated_addr20_oe_n(a_oe));
  xdp_periph_model peer (.a_out, .a_oe_n(a_oe), .kbd_n(kb_n), .aen,
    .a_in, .kbd_cs_n(kcs_n));
  task chk(input string nm, input logic s, input logic e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask
  task rst(input logic l, input logic m);
    nrst = 0;
    l2 = l;
    m486 = m;
    repeat (10) @(negedge clk_sys);
    nrst = 1;
    repeat (2) @(negedge clk_sys);
  endtask
  // one read cycle, held past the pin synchroniser lag
  task cyc(input logic [31:0] a, input logic m, input logic e, input logic c);
    @(negedge clk_sys);
    {adr, mem, aen, act, mrd_n, ird_n} = {a, m, e, c, !(m && c), m || !c};
    repeat (8) @(negedge clk_sys);
  endtask
  task t_io;
    logic [15:0] p [4] = '{16'h0060, 16'h0064, 16'h0070, 16'h0071};
    foreach (p[i]) begin
      cyc({16'h0, p[i]}, 0, 0, 1);
      chk("dir", dir, 0);
      chk("rtc", rtc, p[i] == 16'h0070);
      chk("qual", q_n, p[i] != 16'h0070);
      chk("kbd", kcs_n, p[i][4]);
    end
    cyc(32'h70, 0, 1, 1);
    chk("aen rtc", rtc, 0);
  endtask
  task t_rom;
    cyc(32'h000E0000, 1, 0, 1);
    chk("rom", rom_n, 0);
    chk("dir rom", dir, 0);
    cyc(32'h000DFFFF, 1, 0, 1);
    chk("rom out", rom_n, 1);
    cyc(0, 0, 0, 0);
    chk("dir idle", dir, 1);
    chk("a20", a_in, 1);
    frc = 1;
    repeat (2) @(negedge clk_sys);
    chk("a20 mask", a_in, 0);
  endtask
  task t_l2;
    el = 1;
    cyc(32'h70, 0, 0, 1);
    chk("l2 qual", q_n, 0);
    chk("l2 dir", dir, 0);
    chk("l2 rom", rom_n, 0);
    chk("l2 kbd", kb_n, 0);
  endtask
  // 386 mode: pin driven low while forced, released to the pull-up after
  task t_386;
    frc = 1;
    repeat (2) @(negedge clk_sys);
    chk("a20 drive", a_oe, 0);
    chk("a20 forced", a_in, 0);
    frc = 0;
    repeat (2) @(negedge clk_sys);
    chk("a20 release", a_oe, 1);
    chk("a20 pull", a_in, 1);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst(0, 1);
    t_io;
    t_rom;
    rst(0, 0);
    t_386;
    rst(1, 1);
    t_l2;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
